// >>> hw/ubd_driver.sv
// Sixteen-bit bus driver: per bit a storage element that is transparent or
// edge-captured, feeding a three-state output split into value and enable.
// Assumes all pins, including the capture clock, are asynchronous to clk.
`timescale 1ns/1ps
`default_nettype none
`include "ubd_map.svh"

module ubd_driver
   import ubd_pkg::*;
#(
   parameter int WIDTH = `UBD_WIDTH
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] data_in,
   input wire logic store_mode,
   input wire logic drive_off_n,
   input wire logic cap_clk,
   output logic [WIDTH-1:0] data_out,
   output logic data_oe_n
);

   localparam int SW = WIDTH + `UBD_PIN_DATA;
   localparam logic [WIDTH-1:0] STORE_RST = WIDTH'(`UBD_STORE_RST);
   // Drive-off resets high so the pins stay released until the pin is seen
   localparam logic [SW-1:0] SYNC_RST =
      {STORE_RST, `UBD_MODE_RST, `UBD_OFF_RST, `UBD_CAP_RST};

   // ----------------------------------------------------------------
   // Decoding
   // ----------------------------------------------------------------
   // Rising edge of a sampled level; shared by capture logic and checks
   function automatic logic rise_of(input logic cur, input logic prev);
      return cur & ~prev;
   endfunction : rise_of

   // ----------------------------------------------------------------
   // Pin synchronisation
   // ----------------------------------------------------------------
   logic [SW-1:0] pins_raw;
   logic [SW-1:0] pins_s;
   logic [WIDTH-1:0] data_s;
   logic mode_s;
   logic off_n_s;
   logic cap_s;
   logic cap_prev_r;
   logic cap_rise;

   assign pins_raw = {data_in, store_mode, drive_off_n, cap_clk};

   // All pins share one latency, so data and capture edge stay aligned
   ubd_sync #(
      .WIDTH(SW),
      .RST_VAL(SYNC_RST)
   ) u_sync (
      .clk(clk),
      .rst(rst),
      .async_in(pins_raw),
      .sync_out(pins_s)
   );

   assign data_s = pins_s[SW-1:`UBD_PIN_DATA];
   assign mode_s = pins_s[`UBD_PIN_MODE];
   assign off_n_s = pins_s[`UBD_PIN_OFF];
   assign cap_s = pins_s[`UBD_PIN_CAP];

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cap_prev_r <= `UBD_CAP_RST;
      end else begin
         cap_prev_r <= cap_s;
      end
   end

   // Capture clock must stay at each level for over two clk periods
   assign cap_rise = rise_of(cap_s, cap_prev_r);

   // ----------------------------------------------------------------
   // Storage elements
   // ----------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               data_out[i] <= STORE_RST[i];
            end else if (!mode_s) begin
               data_out[i] <= data_s[i];
            end else if (cap_rise) begin
               data_out[i] <= data_s[i];
            end
            // Otherwise hold: store mode with no rising capture edge
         end

         a_bit_follow: assert property (
            @(posedge clk) disable iff (rst)
            !mode_s |=> data_out[i] == $past(data_s[i])
         ) else $error("bit path does not follow its input");

         a_bit_capture: assert property (
            @(posedge clk) disable iff (rst)
            (mode_s && cap_rise) |=> data_out[i] == $past(data_s[i])
         ) else $error("bit path missed its capture edge");

         a_bit_hold: assert property (
            @(posedge clk) disable iff (rst)
            (mode_s && !cap_rise) |=> $stable(data_out[i])
         ) else $error("bit path changed without a capture edge");

         a_bit_track_hiz: assert property (
            @(posedge clk) disable iff (rst)
            (off_n_s && !mode_s) |=> data_out[i] == $past(data_s[i])
         ) else $error("bit path stopped tracking while released");
      end
   endgenerate

   // ----------------------------------------------------------------
   // Output drive
   // ----------------------------------------------------------------
   // Enable is gated alone; storage above never looks at it
   // The three-state pad sits outside: data_oe_n low lets it drive data_out
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         data_oe_n <= `UBD_OFF_RST;
      end else begin
         data_oe_n <= off_n_s;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_off_means_hiz: assert property (
      @(posedge clk) disable iff (rst)
      drive_off_n |-> ##3 data_oe_n
   ) else $error("outputs driven while drive-off pin high");

   a_on_means_drive: assert property (
      @(posedge clk) disable iff (rst)
      !drive_off_n [*3] |-> ##1 !data_oe_n
   ) else $error("outputs not driven while drive-off pin low");

   a_transparent_path: assert property (
      @(posedge clk) disable iff (rst)
      !mode_s |=> data_out == $past(data_s)
   ) else $error("transparent mode output does not follow input");

   a_edge_capture: assert property (
      @(posedge clk) disable iff (rst)
      (mode_s && cap_s && !cap_prev_r) |=> data_out == $past(data_s)
   ) else $error("store mode did not capture on rising edge");

   a_steady_hold: assert property (
      @(posedge clk) disable iff (rst)
      (mode_s && cap_s == cap_prev_r) |=> $stable(data_out)
   ) else $error("store mode output changed without a rising edge");

   a_store_while_off: assert property (
      @(posedge clk) disable iff (rst)
      (off_n_s && mode_s && rise_of(cap_s, cap_prev_r)) |=> data_out == $past(data_s)
   ) else $error("storage stopped capturing while outputs high impedance");

   a_track_while_hiz: assert property (
      @(posedge clk) disable iff (rst)
      (off_n_s && !mode_s) |=> data_out == $past(data_s)
   ) else $error("storage stopped tracking while outputs high impedance");

   a_width_paths: assert property (
      @(posedge clk) disable iff (rst)
      (!mode_s && data_s == {WIDTH{1'h1}}) |=> data_out == {WIDTH{1'h1}}
   ) else $error("not every path carries its bit");

   a_width_zero: assert property (
      @(posedge clk) disable iff (rst)
      (!mode_s && data_s == '0) |=> data_out == '0
   ) else $error("a path is stuck high");

   a_falling_hold: assert property (
      @(posedge clk) disable iff (rst)
      (mode_s && !cap_s && cap_prev_r) |=> $stable(data_out)
   ) else $error("store mode output changed on a falling capture clock");

   a_cap_ignored: assert property (
      @(posedge clk) disable iff (rst)
      (!mode_s && cap_rise) |=> data_out == $past(data_s)
   ) else $error("capture clock disturbed transparent mode");

   a_hold_while_off: assert property (
      @(posedge clk) disable iff (rst)
      (off_n_s && mode_s && !cap_rise) |=> $stable(data_out)
   ) else $error("storage changed while released and holding");

   a_oe_pipeline: assert property (
      @(posedge clk) disable iff (rst)
      data_oe_n == $past(off_n_s)
   ) else $error("output enable does not follow the synchronised pin");

   a_reset_hiz: assert property (
      @(posedge clk)
      $fell(rst) |-> data_oe_n [*3]
   ) else $error("outputs driven before the drive-off pin was seen");

   // ----------------------------------------------------------------
   // Checks from the pins
   // ----------------------------------------------------------------
   // A pin sampled at one edge shows at the outputs three edges on
   a_pin_to_out: assert property (
      @(posedge clk) disable iff (rst)
      !store_mode |-> ##3 data_out == $past(data_in, 3)
   ) else $error("transparent pin path has the wrong latency or value");

   a_pin_capture: assert property (
      @(posedge clk) disable iff (rst)
      (store_mode && $rose(cap_clk)) |-> ##3 data_out == $past(data_in, 3)
   ) else $error("capture pin edge did not store the input pins");

   a_pin_hold: assert property (
      @(posedge clk) disable iff (rst)
      (store_mode && !$rose(cap_clk)) |-> ##3 $stable(data_out)
   ) else $error("store mode output changed without a capture pin edge");

endmodule : ubd_driver

`default_nettype wire

// >>> shared/ubd_map.svh
// Constants for the sixteen-bit store-and-drive bus driver.
// Assumes one 200 MHz system clock; every pin is asynchronous to it.
// How it works
// - Sixteen identical one-bit paths carry the input bus to the output bus.
// - Drive-off pin high puts every output bit in high impedance, whatever else happens.
// - Store mode low: outputs follow inputs, the capture clock is ignored.
// - Store mode high: inputs are captured on a rising capture clock edge.
// - Store mode high with a steady capture clock: outputs hold, inputs ignored.
`ifndef UBD_MAP_SVH
`define UBD_MAP_SVH

// ----------------------------------------------------------------
// Sizes and reset values
// ----------------------------------------------------------------
`define UBD_WIDTH 16
`define UBD_SYNC_STAGES 2
`define UBD_STORE_RST 16'h0000
`define UBD_OFF_RST 1'h1
`define UBD_MODE_RST 1'h0
`define UBD_CAP_RST 1'h0

// ----------------------------------------------------------------
// Field positions in the synchronised pin vector
// ----------------------------------------------------------------
`define UBD_PIN_CAP 0
`define UBD_PIN_OFF 1
`define UBD_PIN_MODE 2
`define UBD_PIN_DATA 3

`endif

// >>> shared/ubd_pkg.sv
// Types shared by the bus driver modules.
// Assumes ubd_map.svh is on the include path.
`include "ubd_map.svh"

package ubd_pkg;

   // ----------------------------------------------------------------
   // Pin group as seen at the package boundary
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [`UBD_WIDTH-1:0] data;
      logic store_mode;
      logic drive_off_n;
      logic cap_clk;
   } ubd_pins_t;

   localparam int UBD_PINS_W = $bits(ubd_pins_t);

endpackage : ubd_pkg

// >>> hw/ubd_sync.sv
// Two-flop synchroniser for a vector of asynchronous pins.
// Assumes each bit is a level; no bus coherency is promised across bits.
`timescale 1ns/1ps
`default_nettype none

module ubd_sync #(
   parameter int WIDTH = 1,
   // Per-bit reset level, so a disable pin can come up released
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_r;

   // First stage is read only by the second stage
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_r <= RST_VAL;
         sync_out <= RST_VAL;
      end else begin
         meta_r <= async_in;
         sync_out <= meta_r;
      end
   end

endmodule : ubd_sync

`default_nettype wire

// >>> tb/ubd_load_model.sv
// Loads on the driven output bus, resolving the three-state pins.
// Assumes data_oe_n low means the driver owns the pins.
`timescale 1ns/1ps
`default_nettype none

module ubd_load_model (
   input wire logic [15:0] data_out,
   input wire logic data_oe_n,
   output logic [15:0] pin
);
   logic [15:0] last_r = 16'h0000;
   // Released bus shows inverse of last level, so a stale value never passes
   always_comb pin = data_oe_n ? ~last_r : data_out;
   always @(data_out or data_oe_n) if (!data_oe_n) last_r = data_out;
endmodule : ubd_load_model

`default_nettype wire

// >>> tb/sixteen_bit_latch_register_driver_tb_top.sv
// Self-checking bench for the bus driver, random modes and data.
// Assumes outputs settle three clk edges after a pin change.
`timescale 1ns/1ps
`default_nettype none

module sixteen_bit_latch_register_driver_tb_top;
   import ubd_pkg::*;
   logic clk = 1'h0;
   logic rst = 1'h1;
   ubd_pins_t p = '0;
   logic [15:0] data_out;
   logic [15:0] pin;
   logic data_oe_n;
   logic [31:0] seed = 32'hFBDB088F;
   int error_cnt = 0;
   int tests_run = 0;

   ubd_driver i_ubd_driver (.clk(clk), .rst(rst), .data_in(p.data),
      .store_mode(p.store_mode), .drive_off_n(p.drive_off_n), .cap_clk(p.cap_clk),
      .data_out(data_out), .data_oe_n(data_oe_n));
   ubd_load_model i_ubd_load_model (.data_out(data_out), .data_oe_n(data_oe_n), .pin(pin));

   initial forever #2.5 clk = ~clk;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction : xs

   function automatic logic [15:0] keep(input logic m, r, input logic [15:0] d, h);
      return (!m || r) ? d : h;
   endfunction : keep

   task automatic step(input int n);
      repeat (n) @(negedge clk);
   endtask : step

   task automatic cmp(input logic [15:0] got, exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h exp %h", $time, got, exp);
      end
   endtask : cmp

   task automatic end_of_test();
      if (error_cnt == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : end_of_test

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      logic [15:0] held;
      logic [15:0] d;
      held = 16'h0000;
      repeat (12) @(posedge clk);
      @(negedge clk);
      rst = 1'h0;
      for (int i = 0; i < 60; i++) begin
         seed = xs(seed);
         // Corner patterns first, then random
         d = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : seed[15:0];
         p.data = d;
         p.drive_off_n = seed[16];
         p.store_mode = (i < 2) ? 1'h0 : seed[17];
         step(4);
         held = keep(p.store_mode, 1'h0, d, held);
         cmp(data_out, held);
         cmp({15'h0000, data_oe_n}, {15'h0000, p.drive_off_n});
         p.cap_clk = 1'h1;
         step(4);
         held = keep(p.store_mode, 1'h1, d, held);
         cmp(data_out, held);
         if (!p.drive_off_n) cmp(pin, held);
         // In store mode, fresh data while the capture clock sits high must not get in
         p.data = ~d;
         step(4);
         held = keep(p.store_mode, 1'h0, ~d, held);
         cmp(data_out, held);
         p.cap_clk = 1'h0;
      end
      end_of_test();
   end
endmodule : sixteen_bit_latch_register_driver_tb_top

`default_nettype wire
